// >>> design/pt8_pkg.sv
// Purpose: constants for the 8-bit periodic timer
// Assumes: 50 MHz system clock, classic Wishbone register access
// Notes:   offsets are register indices; byte address is index times four
package pt8_pkg;
  // ----------------------------------------
  // register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0]  IDX_INT_FLAGS   = 8'h0C;
  localparam logic [7:0]  IDX_COUNT       = 8'h11;
  localparam logic [7:0]  IDX_CONTROL     = 8'h12;
  localparam logic [7:0]  IDX_INT_ENABLES = 8'h8C;
  localparam logic [7:0]  IDX_PERIOD      = 8'h92;
  localparam logic [9:0]  ADR_INT_FLAGS   = {IDX_INT_FLAGS, 2'b00};
  localparam logic [9:0]  ADR_COUNT       = {IDX_COUNT, 2'b00};
  localparam logic [9:0]  ADR_CONTROL     = {IDX_CONTROL, 2'b00};
  localparam logic [9:0]  ADR_INT_ENABLES = {IDX_INT_ENABLES, 2'b00};
  localparam logic [9:0]  ADR_PERIOD      = {IDX_PERIOD, 2'b00};
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          BIT_MATCH_FLAG  = 1;
  localparam int          BIT_TIMER_ON    = 2;
  localparam int          POS_PSC_LO      = 0;
  localparam int          POS_POST_LO     = 3;
  localparam logic [7:0]  RST_PERIOD      = 8'hFF;
  localparam logic [7:0]  RST_COUNT       = 8'h00;
  localparam logic [6:0]  RST_CONTROL     = 7'h00;
  localparam logic [7:0]  CONTROL_MASK    = 8'h7F;
  localparam logic [7:0]  FLAG_MASK       = 8'h02;
  // ----------------------------------------
  // prescaler terminal counts (ratio minus one)
  // ----------------------------------------
  localparam logic [3:0]  PSC_TC_DIV1     = 4'h0;
  localparam logic [3:0]  PSC_TC_DIV4     = 4'h3;
  localparam logic [3:0]  PSC_TC_DIV16    = 4'hF;
  localparam logic [1:0]  QDIV_TC         = 2'h3;
endpackage : pt8_pkg

// >>> design/pt8_prescaler.sv
// Purpose: instruction clock divider and selectable prescaler
// Assumes: i_clr from same clock domain
// Notes:   emits one-cycle tick per counter increment
`timescale 1ns/1ps
module pt8_prescaler
  import pt8_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_clr,
  input  wire logic [1:0] i_sel,
  output logic            o_tick
);
  logic [1:0] qdiv_q;
  logic [3:0] psc_q;
  logic [3:0] tc;
  logic       inst_tick;

  always_comb begin
    unique case (i_sel)
      2'b00:   tc = PSC_TC_DIV1;
      2'b01:   tc = PSC_TC_DIV4;
      default: tc = PSC_TC_DIV16;
    endcase
  end

  assign inst_tick = i_run && (qdiv_q == QDIV_TC);

  // ----------------------------------------
  // fosc/4 divider; holds while stopped
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qdiv_q <= 2'h0;
    end else if (i_run) begin
      qdiv_q <= qdiv_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psc_q <= 4'h0;
    end else if (i_clr) begin
      psc_q <= 4'h0;
    end else if (inst_tick) begin
      psc_q <= (psc_q >= tc) ? 4'h0 : psc_q + 4'h1;
    end
  end

  assign o_tick = inst_tick && !i_clr && (psc_q >= tc);
endmodule : pt8_prescaler

// >>> design/pt8_timer.sv
// Purpose: 8-bit periodic timer with prescaler, period and postscaler
// Assumes: classic Wishbone slave, 32-bit data, byte address = index * 4
// Notes:   ack one cycle after request; stays low one cycle after
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module pt8_timer
  import pt8_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [9:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  output logic             O_MATCH,
  output logic             O_IRQ
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] count_q;
  logic [7:0] period_q;
  logic [6:0] control_q;
  logic       flag_q;
  logic       enable_q;
  logic [3:0] post_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       match_q;
  logic       irq_q;

  logic       req;
  logic       wr;
  logic       wr_count;
  logic       wr_control;
  logic       wr_period;
  logic       wr_flags;
  logic       wr_enables;
  logic       timer_on;
  logic       tick;
  logic       match;
  logic       post_fire;
  logic [3:0] post_sel;
  logic [7:0] rd_mux;

  assign timer_on = control_q[BIT_TIMER_ON];
  assign post_sel = control_q[POS_POST_LO +: 4];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // single-cycle request; ack_q blocks a second take on the release edge
  assign req        = I_WB_CYC && I_WB_STB && !ack_q;
  assign wr         = req && I_WB_WE && I_WB_SEL[0];
  assign wr_count   = wr && (I_WB_ADR == ADR_COUNT);
  assign wr_control = wr && (I_WB_ADR == ADR_CONTROL);
  assign wr_period  = wr && (I_WB_ADR == ADR_PERIOD);
  assign wr_flags   = wr && (I_WB_ADR == ADR_INT_FLAGS);
  assign wr_enables = wr && (I_WB_ADR == ADR_INT_ENABLES);

  always_comb begin
    unique case (I_WB_ADR)
      ADR_COUNT:       rd_mux = count_q;
      ADR_CONTROL:     rd_mux = {1'b0, control_q};
      ADR_PERIOD:      rd_mux = period_q;
      ADR_INT_FLAGS:   rd_mux = {6'h00, flag_q, 1'b0};
      ADR_INT_ENABLES: rd_mux = {6'h00, enable_q, 1'b0};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      control_q <= RST_CONTROL;
    end else if (wr_control) begin
      control_q <= I_WB_DAT[6:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      period_q <= RST_PERIOD;
    end else if (wr_period) begin
      period_q <= I_WB_DAT[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      enable_q <= 1'b0;
    end else if (wr_enables) begin
      enable_q <= I_WB_DAT[BIT_MATCH_FLAG];
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // stopping the divider too, not just gating ticks, saves the power
  pt8_prescaler u_psc (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_run   (timer_on),
    .i_clr   (wr_count || wr_control),
    .i_sel   (control_q[POS_PSC_LO +: 2]),
    .o_tick  (tick)
  );

  // ----------------------------------------
  // counter and match
  // ----------------------------------------
  assign match = tick && !wr_count && (count_q == period_q);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      count_q <= RST_COUNT;
    end else if (wr_count) begin
      count_q <= I_WB_DAT[7:0];
    end else if (match) begin
      count_q <= 8'h00;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end
  // control write leaves count_q alone by construction

  // ----------------------------------------
  // postscaler
  // ----------------------------------------
  assign post_fire = match && (post_q == post_sel);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      post_q <= 4'h0;
    end else if (wr_count || wr_control) begin
      post_q <= 4'h0;
    end else if (match) begin
      post_q <= post_fire ? 4'h0 : post_q + 4'h1;
    end
  end

  // ----------------------------------------
  // flag, outputs
  // ----------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag_q <= 1'b0;
    end else if (post_fire) begin
      flag_q <= 1'b1;
    end else if (wr_flags) begin
      flag_q <= I_WB_DAT[BIT_MATCH_FLAG];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      match_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      match_q <= match;
      irq_q   <= flag_q && enable_q;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;
  assign O_MATCH  = match_q;
  assign O_IRQ    = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PERIOD_RESET: assert property (@(posedge I_CLK) $rose(I_RST_N) |-> period_q == RST_PERIOD)
    else $error("period not FF after reset");
  AST_WRAP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    match |=> count_q == 8'h00 && match_q)
    else $error("match did not wrap counter");
  AST_INC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    tick && !match && !wr_count |=> count_q == $past(count_q) + 8'h01)
    else $error("counter did not increment");
  // only undisturbed stretches: a scaler clear legally delays the next tick
  AST_DIV1: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    tick && control_q[1:0] == 2'b00 && timer_on ##1 (!wr_count && !wr_control)[*4]
    |-> tick)
    else $error("divide by one spacing wrong");
  // switching on may tick at once, so the event is judged in the off cycle itself
  AST_OFF_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !timer_on && !wr_count |=> count_q == $past(count_q) && !$past(post_fire))
    else $error("counter moved while off");
  AST_CTRL_KEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    wr_control |=> count_q == $past(count_q) && post_q == 4'h0)
    else $error("control write disturbed counter");
  AST_FLAG_SET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    post_fire |=> flag_q)
    else $error("postscaler did not set flag");
  AST_IRQ_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_IRQ |-> $past(flag_q) && $past(enable_q))
    else $error("irq without enabled flag");
  AST_CTRL_B7: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ack_q && $past(I_WB_ADR) == ADR_CONTROL && !$past(I_WB_WE) |-> !O_WB_DAT[7])
    else $error("control bit 7 read as one");
endmodule : pt8_timer

// >>> verif/tb_pt8_timer.sv
// Purpose: self-checking bench for the 8-bit periodic timer
// Assumes: one-cycle Wishbone ack, registers in lane 0
// Notes:   match spacing is measured between O_MATCH pulses
`timescale 1ns/1ps
module tb_pt8_timer;
  import pt8_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [9:0]  adr       = 10'h000;
  logic [31:0] wdat      = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        match;
  logic        irq;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  // ----------------------------------------
  // clock, timeout, design
  // ----------------------------------------
  always #10 clk = ~clk;

  // whole run is a few thousand cycles; generous ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      results();
    end
  end

  pt8_timer u_pt8_timer (
    .I_CLK    (clk),
    .I_RST_N  (rst_n),
    .I_WB_CYC (cyc),
    .I_WB_STB (stb),
    .I_WB_WE  (we),
    .I_WB_ADR (adr),
    .I_WB_SEL (4'hF),
    .I_WB_DAT (wdat),
    .O_WB_DAT (rdat),
    .O_WB_ACK (ack),
    .O_MATCH  (match),
    .O_IRQ    (irq)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // request held until ack is sampled; released at that same edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask : rd_chk

  task automatic next_match(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match !== 1'b1 && n < 2000);
  endtask : next_match

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(ADR_COUNT, 32'h0000_0000, "count");
    rd_chk(ADR_CONTROL, 32'h0000_0000, "control");
    rd_chk(ADR_PERIOD, 32'h0000_00FF, "period");
    rd_chk(ADR_INT_FLAGS, 32'h0000_0000, "flags");
    rd_chk(ADR_INT_ENABLES, 32'h0000_0000, "enables");
    rd_chk(10'h3FC, 32'h0000_0000, "unmapped");
  endtask : t_reset

  task automatic t_regs();
    int n = 0;
    wb(1'b1, ADR_CONTROL, 32'h0000_00FB);
    rd_chk(ADR_CONTROL, 32'h0000_007B, "control bit7");
    wb(1'b1, ADR_COUNT, 32'h0000_00A5);
    rd_chk(ADR_COUNT, 32'h0000_00A5, "count rw");
    wb(1'b1, ADR_CONTROL, 32'h0000_0000);
    rd_chk(ADR_COUNT, 32'h0000_00A5, "count kept");
    wb(1'b1, ADR_PERIOD, 32'h0000_005A);
    rd_chk(ADR_PERIOD, 32'h0000_005A, "period rw");
    repeat (100) begin
      @(posedge clk);
      if (match === 1'b1) n++;
    end
    chk("match while off", n, 0);
    rd_chk(ADR_COUNT, 32'h0000_00A5, "count off");
  endtask : t_regs

  task automatic t_spacing();
    int n;
    wb(1'b1, ADR_PERIOD, 32'h0000_0003);
    wb(1'b1, ADR_COUNT, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, ADR_CONTROL, 32'(4 + s));
      next_match(n);
      next_match(n);
      chk("spacing", n, 16 * (s == 0 ? 1 : s == 1 ? 4 : 16));
    end
  endtask : t_spacing

  // writes every 43 cycles starve a 64-cycle prescale if they clear it
  task automatic t_clear();
    int n = 0;
    wb(1'b1, ADR_PERIOD, 32'h0000_0000);
    wb(1'b1, ADR_CONTROL, 32'h0000_0006);
    repeat (8) begin
      wb(1'b1, ADR_COUNT, 32'h0000_0000);
      repeat (40) begin
        @(posedge clk);
        if (match === 1'b1) n++;
      end
    end
    chk("scaler clear", n, 0);
  endtask : t_clear

  task automatic t_post();
    int n;
    int nv[3] = '{0, 2, 15};
    wb(1'b1, ADR_PERIOD, 32'h0000_0001);
    wb(1'b1, ADR_INT_ENABLES, 32'h0000_0002);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ADR_CONTROL, 32'h0000_0000);
      wb(1'b1, ADR_INT_FLAGS, 32'h0000_0000);
      wb(1'b1, ADR_COUNT, 32'h0000_0000);
      chk("irq low", irq, 1'b0);
      wb(1'b1, ADR_CONTROL, 32'(4 | (nv[k] << 3)));
      n = 0;
      repeat (400) begin
        @(posedge clk);
        if (match === 1'b1) n++;
        if (irq === 1'b1) break;
      end
      chk("postscale", n, nv[k] + 1);
    end
    wb(1'b1, ADR_CONTROL, 32'h0000_0000);
    rd_chk(ADR_INT_FLAGS, 32'h0000_0002, "flag set");
    wb(1'b1, ADR_INT_ENABLES, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 1'b0);
    rd_chk(ADR_INT_FLAGS, 32'h0000_0002, "flag sticky");
  endtask : t_post

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_spacing();
    t_clear();
    t_post();
    results();
  end
endmodule : tb_pt8_timer
